// File: include/periodic_timer_pkg.sv
// package: register map, field layout, reset values and state types of the periodic timer
package periodic_timer_pkg;

  // register byte offsets on the axi4-lite slave
  localparam logic [7:0] OFS_RUN_CONTROL   = 8'h00;
  localparam logic [7:0] OFS_MODE_CONTROL  = 8'h04;
  localparam logic [7:0] OFS_COUNT_LOW     = 8'h08;
  localparam logic [7:0] OFS_COUNT_HIGH    = 8'h0c;
  localparam logic [7:0] OFS_COMPARE_A_LOW = 8'h10;
  localparam logic [7:0] OFS_COMPARE_A_HI  = 8'h14;
  localparam logic [7:0] OFS_COMPARE_P_LOW = 8'h18;
  localparam logic [7:0] OFS_COMPARE_P_HI  = 8'h1c;
  localparam logic [7:0] MAP_LAST          = 8'h1f;

  // field positions in run control
  localparam int RUN_BIT_POS  = 3;
  localparam int EXT_SRC_POS  = 4;
  // field positions in timer_mode_output_control
  localparam int OP_MODE_POS  = 6;
  localparam int PIN_ACT_POS  = 4;
  localparam int OUT_CTL_POS  = 3;
  localparam int OUT_POL_POS  = 2;
  localparam int CAP_SRC_POS  = 1;
  localparam int CLR_SEL_POS  = 0;
  // high byte holds counter bits 9..8 in bits 1..0
  localparam int HIGH_BITS    = 2;

  // reset values
  localparam logic [7:0] MODE_CONTROL_RESET = 8'h00;
  localparam logic [9:0] VALUE_RESET        = 10'h000;
  localparam logic [10:0] FULL_PERIOD       = 11'h400;

  // axi responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {MODE_COMPARE, MODE_CAPTURE, MODE_PWM, MODE_TIMER} op_mode_t;
  typedef enum logic [1:0] {ACT_00, ACT_01, ACT_10, ACT_11} pin_action_t;

  // software-visible configuration
  typedef struct packed {
    logic        run_bit;
    logic        ext_src;
    op_mode_t    op_mode;
    pin_action_t pin_action;
    logic        output_control;
    logic        output_polarity;
    logic        capture_source_sel;
    logic        clear_select;
    logic [9:0]  compare_a_value;
    logic [9:0]  compare_p_value;
  } regs_t;

  // whole module state
  typedef struct packed {
    regs_t       regs;
    logic        run_d;
    logic [9:0]  counter;
    logic        out_level;
    logic        timer_out_pin;
    logic [2:0]  cap_sync;
    logic [2:0]  ext_sync;
    logic        aw_full;
    logic        w_full;
    logic [7:0]  awaddr;
    logic [7:0]  wdata;
    logic        wstrb0;
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } state_t;

endpackage : periodic_timer_pkg

// File: rtl/periodic_timer.sv
// periodic timer: 10-bit counter, two comparators, output and capture pins, axi4-lite registers
//
// Summary of operation
// [RQ1] mode field: 00 compare output, 01 capture, 10 pwm/single pulse, 11 timer.
// [RQ2] software stops the timer before changing the mode field.
// [RQ3] software keeps the output pin unused in timer/counter mode.
// [RQ4] compare mode: match A leaves, lowers, raises or toggles the output.
// [RQ5] pwm mode: action forces inactive, forces active, runs pwm, or single pulse.
// [RQ6] capture mode: capture on rising, falling, both edges, or not at all.
// [RQ7] a match requesting the present level causes no visible pin change.
// [RQ8] run bit rising edge returns the output to its initial level.
// [RQ9] software changes the pin action in pwm mode only while stopped.
// [RQ10] output control: initial level, pwm active level, single pulse start level.
// [RQ11] polarity bit set inverts the output pin.
// [RQ12] output control and polarity do nothing in timer/counter mode.
// [RQ13] capture source: capture pin when 0, external clock pin when 1.
// [RQ14] clear select 1 clears on match A, 0 on match P or overflow.
// [RQ15] overflow clearing happens only when compare P is all zero.
// [RQ16] clear select is ignored in pwm, single pulse and capture modes.
// [RQ17] counter reads only, low byte bits 7..0, high byte bits 9..8.
// [RQ18] compare A is 10-bit read/write in two bytes, reset zero.
// [RQ19] compare P is 10-bit read/write in two bytes, reset zero.
// [RQ20] counter is a 10-bit up-counter on internal or external clock.
// [RQ21] run rising edge zeroes the counter, falling edge freezes it.
module periodic_timer (
  // clock, reset, enable
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        ce,
  // axi4-lite write channels
  input  wire logic [7:0]  awaddr,
  input  wire logic        awvalid,
  output logic             awready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        wvalid,
  output logic             wready,
  output logic             bvalid,
  output logic [1:0]       bresp,
  input  wire logic        bready,
  // axi4-lite read channels
  input  wire logic [7:0]  araddr,
  input  wire logic        arvalid,
  output logic             arready,
  output logic             rvalid,
  output logic [31:0]      rdata,
  output logic [1:0]       rresp,
  input  wire logic        rready,
  // timer pins
  input  wire logic        capture_in_pin,
  input  wire logic        ext_clock_pin,
  output logic             timer_out_pin
);

  periodic_timer_pkg::state_t st;
  periodic_timer_pkg::state_t next_st;

  // compare P of zero means a full 1024-count period, i.e. clear on overflow
  function automatic logic [10:0] period_of(input logic [9:0] p);
    period_of = (p == 10'h000) ? periodic_timer_pkg::FULL_PERIOD : {1'b0, p};
  endfunction : period_of

  // register read mux; unmapped bytes of a word read as zero
  function automatic logic [31:0] read_word(input logic [7:0] a, input periodic_timer_pkg::state_t s);
    logic [7:0] b;
    b = 8'h00;
    unique case (a[4:2])
      3'h0: b = {3'h0, s.regs.ext_src, s.regs.run_bit, 3'h0};
      3'h1: b = {s.regs.op_mode, s.regs.pin_action, s.regs.output_control, s.regs.output_polarity,
                 s.regs.capture_source_sel, s.regs.clear_select};
      3'h2: b = s.counter[7:0];                                          // see [RQ17]
      3'h3: b = {6'h00, s.counter[9:8]};                                 // see [RQ17]
      3'h4: b = s.regs.compare_a_value[7:0];
      3'h5: b = {6'h00, s.regs.compare_a_value[9:8]};
      3'h6: b = s.regs.compare_p_value[7:0];
      3'h7: b = {6'h00, s.regs.compare_p_value[9:8]};
    endcase
    read_word = {24'h000000, b};
  endfunction : read_word

  function automatic logic mapped(input logic [7:0] a);
    mapped = (a <= periodic_timer_pkg::MAP_LAST);
  endfunction : mapped

  // combinational event terms shared by next-state logic and assertions
  logic        run_rise;
  logic        run_fall;
  logic        ext_rise;
  logic        cap_rise;
  logic        cap_fall;
  logic        tick;
  logic [10:0] cnt_inc;
  logic        a_hit;
  logic        p_hit;
  logic        single;
  logic        cap_edge;
  logic        do_write;

  always_comb
  begin
    run_rise = st.regs.run_bit && !st.run_d;
    run_fall = !st.regs.run_bit && st.run_d;
    ext_rise = st.ext_sync[1] && !st.ext_sync[2];
    // capture trigger taken from the selected pin
    cap_rise = st.regs.capture_source_sel ? ext_rise : (st.cap_sync[1] && !st.cap_sync[2]);  // see [RQ13]
    cap_fall = st.regs.capture_source_sel ? (!st.ext_sync[1] && st.ext_sync[2])
                                          : (!st.cap_sync[1] && st.cap_sync[2]);           // see [RQ13]
    // no tick in the run-rise cycle so the zeroed count is never overtaken
    tick     = st.regs.run_bit && st.run_d && (!st.regs.ext_src || ext_rise);            // see [RQ20]
    cnt_inc  = {1'b0, st.counter} + 11'h001;
    a_hit    = tick && (cnt_inc == {1'b0, st.regs.compare_a_value});
    p_hit    = tick && (cnt_inc == period_of(st.regs.compare_p_value));
    single   = (st.regs.op_mode == periodic_timer_pkg::MODE_PWM)
               && (st.regs.pin_action == periodic_timer_pkg::ACT_11);
    cap_edge = 1'b0;
    if (st.regs.op_mode == periodic_timer_pkg::MODE_CAPTURE)
    begin
      unique case (st.regs.pin_action)                                    // see [RQ6]
        periodic_timer_pkg::ACT_00: cap_edge = cap_rise;
        periodic_timer_pkg::ACT_01: cap_edge = cap_fall;
        periodic_timer_pkg::ACT_10: cap_edge = cap_rise || cap_fall;
        periodic_timer_pkg::ACT_11: cap_edge = 1'b0;
      endcase
    end
    do_write = st.aw_full && st.w_full && !st.bvalid;
  end

  // next state: synchronisers, timer core, then bus
  always_comb
  begin
    next_st = st;
    // two flops before use; bit 2 only serves edge detection
    next_st.cap_sync = {st.cap_sync[1:0], capture_in_pin};
    next_st.ext_sync = {st.ext_sync[1:0], ext_clock_pin};
    next_st.run_d    = st.regs.run_bit;

    // counter                                                           
    if (run_rise)
      next_st.counter = periodic_timer_pkg::VALUE_RESET;                // see [RQ21]
    else if (tick)
    begin
      unique case (st.regs.op_mode)                                     // see [RQ1]
        periodic_timer_pkg::MODE_COMPARE, periodic_timer_pkg::MODE_TIMER:
          if (st.regs.clear_select ? a_hit : p_hit)                     // see [RQ14] [RQ15]
            next_st.counter = periodic_timer_pkg::VALUE_RESET;
          else
            next_st.counter = cnt_inc[9:0];
        default:
          // clear select ignored; single pulse never clears on P
          if (p_hit && !single)                                         // see [RQ16]
            next_st.counter = periodic_timer_pkg::VALUE_RESET;
          else
            next_st.counter = cnt_inc[9:0];
      endcase
    end

    // output level before polarity
    if (run_rise)
      next_st.out_level = st.regs.output_control;                       // see [RQ8] [RQ10]
    if (st.regs.op_mode == periodic_timer_pkg::MODE_COMPARE && a_hit)
    begin
      // a set to the present level is invisible by construction
      unique case (st.regs.pin_action)                                  // see [RQ4] [RQ7]
        periodic_timer_pkg::ACT_00: next_st.out_level = st.out_level;
        periodic_timer_pkg::ACT_01: next_st.out_level = 1'b0;
        periodic_timer_pkg::ACT_10: next_st.out_level = 1'b1;
        periodic_timer_pkg::ACT_11: next_st.out_level = !st.out_level;
      endcase
    end
    if (single)
    begin
      // an external clock edge starts the pulse while stopped
      if (!st.regs.run_bit && ext_rise)
        next_st.regs.run_bit = 1'b1;
      if (a_hit)
      begin
        next_st.regs.run_bit = 1'b0;                                    // see [RQ5]
        next_st.out_level    = !st.regs.output_control;
      end
      if (run_fall)
        next_st.out_level = !st.regs.output_control;
    end
    else if (st.regs.op_mode == periodic_timer_pkg::MODE_PWM)
    begin
      // duty of compare A at or above the period gives 100%
      unique case (st.regs.pin_action)                                  // see [RQ5] [RQ10]
        periodic_timer_pkg::ACT_00: next_st.out_level = !st.regs.output_control;
        periodic_timer_pkg::ACT_01: next_st.out_level = st.regs.output_control;
        default:
          next_st.out_level = (next_st.counter < st.regs.compare_a_value) ? st.regs.output_control
                                                                          : !st.regs.output_control;
      endcase
    end

    // axi write path; software write wins over hardware run clear
    if (awvalid && st.awready)
    begin
      next_st.aw_full = 1'b1;
      next_st.awaddr  = awaddr;
    end
    if (wvalid && st.wready)
    begin
      next_st.w_full = 1'b1;
      next_st.wdata  = wdata[7:0];
      next_st.wstrb0 = wstrb[0];
    end
    if (st.bvalid && bready)
      next_st.bvalid = 1'b0;
    if (do_write)
    begin
      next_st.aw_full = 1'b0;
      next_st.w_full  = 1'b0;
      next_st.bvalid  = 1'b1;
      next_st.bresp   = mapped(st.awaddr) ? periodic_timer_pkg::RESP_OKAY : periodic_timer_pkg::RESP_SLVERR;
      if (mapped(st.awaddr) && st.wstrb0)
      begin
        unique case (st.awaddr[4:2])
          3'h0:
          begin
            next_st.regs.run_bit = st.wdata[periodic_timer_pkg::RUN_BIT_POS];
            next_st.regs.ext_src = st.wdata[periodic_timer_pkg::EXT_SRC_POS];
          end
          3'h1:
          begin
            next_st.regs.op_mode            = periodic_timer_pkg::op_mode_t'(st.wdata[periodic_timer_pkg::OP_MODE_POS +: 2]);
            next_st.regs.pin_action         = periodic_timer_pkg::pin_action_t'(st.wdata[periodic_timer_pkg::PIN_ACT_POS +: 2]);
            next_st.regs.output_control     = st.wdata[periodic_timer_pkg::OUT_CTL_POS];
            next_st.regs.output_polarity    = st.wdata[periodic_timer_pkg::OUT_POL_POS];
            next_st.regs.capture_source_sel = st.wdata[periodic_timer_pkg::CAP_SRC_POS];
            next_st.regs.clear_select       = st.wdata[periodic_timer_pkg::CLR_SEL_POS];
          end
          3'h4: next_st.regs.compare_a_value[7:0] = st.wdata;           // see [RQ18]
          3'h5: next_st.regs.compare_a_value[9:8] = st.wdata[1:0];      // see [RQ18]
          3'h6: next_st.regs.compare_p_value[7:0] = st.wdata;           // see [RQ19]
          3'h7: next_st.regs.compare_p_value[9:8] = st.wdata[1:0];      // see [RQ19]
          default: next_st.regs = next_st.regs;                         // counter bytes ignore writes
        endcase
      end
    end
    next_st.awready = !next_st.aw_full && !next_st.bvalid;
    next_st.wready  = !next_st.w_full && !next_st.bvalid;

    // capture has priority over a same-cycle software write to compare A
    if (cap_edge)
      next_st.regs.compare_a_value = st.counter;                        // see [RQ6]

    // axi read path
    if (st.rvalid && rready)
      next_st.rvalid = 1'b0;
    if (arvalid && st.arready)
    begin
      next_st.rvalid = 1'b1;
      next_st.rdata  = mapped(araddr) ? read_word(araddr, st) : 32'h00000000;
      next_st.rresp  = mapped(araddr) ? periodic_timer_pkg::RESP_OKAY : periodic_timer_pkg::RESP_SLVERR;
    end
    next_st.arready = !next_st.rvalid;

    // pin unused in timer mode, so control and polarity have no effect there
    next_st.timer_out_pin = (next_st.regs.op_mode == periodic_timer_pkg::MODE_TIMER) ? 1'b0  // see [RQ12]
                            : (next_st.out_level ^ next_st.regs.output_polarity);          // see [RQ11]
  end

  // state register; ce low freezes everything
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      st                       <= '0;
      st.regs.op_mode          <= periodic_timer_pkg::MODE_COMPARE;
      st.regs.pin_action       <= periodic_timer_pkg::ACT_00;
      st.regs.compare_a_value  <= periodic_timer_pkg::VALUE_RESET;
      st.regs.compare_p_value  <= periodic_timer_pkg::VALUE_RESET;
      st.counter               <= periodic_timer_pkg::VALUE_RESET;
      st.awready               <= 1'b1;
      st.wready                <= 1'b1;
      st.arready               <= 1'b1;
    end
    else if (ce)
      st <= next_st;
  end

  // outputs straight from state flops
  assign awready       = st.awready;
  assign wready        = st.wready;
  assign bvalid        = st.bvalid;
  assign bresp         = st.bresp;
  assign arready       = st.arready;
  assign rvalid        = st.rvalid;
  assign rdata         = st.rdata;
  assign rresp         = st.rresp;
  assign timer_out_pin = st.timer_out_pin;

  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  sequence s_run_rise;
    ce && run_rise;
  endsequence

  sequence s_cmp_match;
    ce && a_hit && st.regs.op_mode == periodic_timer_pkg::MODE_COMPARE;
  endsequence

  AST_RUN_RISE_ZERO: assert property (s_run_rise |=> st.counter == 10'h000) // see [RQ21]
    else $error("counter not zeroed on run rise");
  AST_RUN_FREEZE: assert property (ce && !st.regs.run_bit |=> st.counter == $past(st.counter)) // see [RQ21]
    else $error("counter moved while stopped");
  AST_RUN_RISE_LEVEL: assert property (s_run_rise ##0 (st.regs.op_mode == periodic_timer_pkg::MODE_COMPARE)
    |=> st.out_level == $past(st.regs.output_control)) // see [RQ8]
    else $error("output not at initial level after run rise");
  AST_MATCH_LOW: assert property (s_cmp_match ##0 (st.regs.pin_action == periodic_timer_pkg::ACT_01)
    |=> !st.out_level) // see [RQ4]
    else $error("match did not drive low");
  AST_MATCH_TOGGLE: assert property (s_cmp_match ##0 (st.regs.pin_action == periodic_timer_pkg::ACT_11)
    |=> st.out_level != $past(st.out_level)) // see [RQ4]
    else $error("match did not toggle");
  AST_CLEAR_ON_A: assert property (ce && a_hit && st.regs.clear_select
    && st.regs.op_mode == periodic_timer_pkg::MODE_TIMER |=> st.counter == 10'h000) // see [RQ14]
    else $error("clear on compare A missing");
  AST_CLEAR_ON_P: assert property (ce && tick && !st.regs.clear_select && st.regs.op_mode
    == periodic_timer_pkg::MODE_COMPARE && st.regs.compare_p_value == 10'h000 && st.counter == 10'h3ff
    |=> st.counter == 10'h000) // see [RQ15]
    else $error("overflow clear missing");
  AST_CAPTURE: assert property (ce && cap_edge |=> st.regs.compare_a_value == $past(st.counter)) // see [RQ6]
    else $error("capture did not latch counter");
  AST_POLARITY: assert property (ce && !a_hit && !run_rise && st.regs.op_mode == periodic_timer_pkg::MODE_COMPARE
    && next_st.regs.op_mode == periodic_timer_pkg::MODE_COMPARE
    |=> timer_out_pin == ($past(st.out_level) ^ st.regs.output_polarity)) // see [RQ11]
    else $error("polarity not applied");
  AST_TIMER_PIN: assert property (ce && next_st.regs.op_mode == periodic_timer_pkg::MODE_TIMER
    |=> !timer_out_pin) // see [RQ12]
    else $error("pin driven in timer mode");
  AST_PULSE_END: assert property (ce && single && a_hit && !do_write
    |=> !st.regs.run_bit && st.out_level == !$past(st.regs.output_control)) // see [RQ5]
    else $error("single pulse did not end on match A");

endmodule : periodic_timer

// File: sim/periodic_timer_test.sv
// self-checking bench of the periodic timer: registers, counter, compare, pwm and capture
module periodic_timer_test;
  timeunit 1ns;
  timeprecision 1ns;

  // every design input holds a value from time zero
  logic        clk            = 1'b0;
  logic        rst            = 1'b1;
  logic        ce             = 1'b1;
  logic [7:0]  awaddr         = 8'h00;
  logic        awvalid        = 1'b0;
  logic [31:0] wdata          = 32'h00000000;
  logic [3:0]  wstrb          = 4'hf;
  logic        wvalid         = 1'b0;
  logic        bready         = 1'b0;
  logic [7:0]  araddr         = 8'h00;
  logic        arvalid        = 1'b0;
  logic        rready         = 1'b0;
  logic        capture_in_pin = 1'b0;
  logic        ext_clock_pin  = 1'b0;
  logic        awready, wready, bvalid, arready, rvalid, timer_out_pin;
  logic [1:0]  bresp, rresp;
  logic [31:0] rdata;
  int          fail_count     = 0;
  int          comparisons    = 0;
  int          cycles         = 0;

  periodic_timer dut (.clk(clk), .rst(rst), .ce(ce), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bvalid(bvalid), .bresp(bresp),
    .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready), .rvalid(rvalid), .rdata(rdata),
    .rresp(rresp), .rready(rready), .capture_in_pin(capture_in_pin), .ext_clock_pin(ext_clock_pin),
    .timer_out_pin(timer_out_pin));

  // 50 ns period
  initial
  begin
    forever #25 clk = ~clk;
  end

  // hang guard: the whole run needs a few thousand cycles
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      fail_count++;
      report_and_stop();
    end
  end

  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : report_and_stop

  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e)
    begin
      $display("[ERR] %s expected %h seen %h", n, e, g);
      fail_count++;
    end
  endtask : chk

  // address and data offered together, each released once taken; one idle edge after bready drops
  task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] er);
    logic aw_done;
    logic w_done;
    aw_done = 1'b0;
    w_done  = 1'b0;
    awaddr  <= a;
    wdata   <= {24'h000000, d};
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    while (!(aw_done && w_done))
    begin
      @(posedge clk);
      if (!aw_done && awready === 1'b1)
      begin
        aw_done = 1'b1;
        awvalid <= 1'b0;
      end
      if (!w_done && wready === 1'b1)
      begin
        w_done = 1'b1;
        wvalid <= 1'b0;
      end
    end
    do @(posedge clk); while (bvalid !== 1'b1);
    chk("write response", {30'h0, er}, {30'h0, bresp});
    bready <= 1'b0;
    @(posedge clk);
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    do @(posedge clk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge clk); while (rvalid !== 1'b1);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
    @(posedge clk);
  endtask : rd

  task automatic rd_chk(input string n, input logic [7:0] a, input logic [31:0] e);
    logic [31:0] d;
    logic [1:0]  r;
    rd(a, d, r);
    chk(n, e, d);
    chk("read response", {30'h0, periodic_timer_pkg::RESP_OKAY}, {30'h0, r});
  endtask : rd_chk

  // stop, change mode, start again: the mode field is never changed while running
  task automatic restart(input logic [7:0] m);
    wr(periodic_timer_pkg::OFS_RUN_CONTROL, 8'h00, periodic_timer_pkg::RESP_OKAY);
    wr(periodic_timer_pkg::OFS_MODE_CONTROL, m, periodic_timer_pkg::RESP_OKAY);
    wr(periodic_timer_pkg::OFS_RUN_CONTROL, 8'h08, periodic_timer_pkg::RESP_OKAY);
  endtask : restart

  task automatic wr_cmp(input logic [7:0] a_lo, input logic [7:0] a_hi, input logic [7:0] p_lo);
    wr(periodic_timer_pkg::OFS_COMPARE_A_LOW, a_lo, periodic_timer_pkg::RESP_OKAY);
    wr(periodic_timer_pkg::OFS_COMPARE_A_HI, a_hi, periodic_timer_pkg::RESP_OKAY);
    wr(periodic_timer_pkg::OFS_COMPARE_P_LOW, p_lo, periodic_timer_pkg::RESP_OKAY);
    wr(periodic_timer_pkg::OFS_COMPARE_P_HI, 8'h00, periodic_timer_pkg::RESP_OKAY);
  endtask : wr_cmp

  task automatic regs_test();
    logic [31:0] d;
    logic [1:0]  r;
    for (int i = 0; i < 8; i++)
      rd_chk("reset value", 8'(i * 4), 32'h0);
    wr_cmp(8'ha5, 8'hff, 8'h5a);
    rd_chk("compare a low", periodic_timer_pkg::OFS_COMPARE_A_LOW, 32'ha5);
    rd_chk("compare a high", periodic_timer_pkg::OFS_COMPARE_A_HI, 32'h3);
    rd_chk("compare p low", periodic_timer_pkg::OFS_COMPARE_P_LOW, 32'h5a);
    wr(periodic_timer_pkg::OFS_MODE_CONTROL, 8'hb6, periodic_timer_pkg::RESP_OKAY);
    rd_chk("mode control", periodic_timer_pkg::OFS_MODE_CONTROL, 32'hb6);
    wr(periodic_timer_pkg::OFS_COUNT_LOW, 8'h77, periodic_timer_pkg::RESP_OKAY);
    rd_chk("count low", periodic_timer_pkg::OFS_COUNT_LOW, 32'h0);
    wr(8'h20, 8'h11, periodic_timer_pkg::RESP_SLVERR);
    rd(8'h20, d, r);
    chk("unmapped data", 32'h0, d);
    chk("unmapped response", {30'h0, periodic_timer_pkg::RESP_SLVERR}, {30'h0, r});
  endtask : regs_test

  task automatic counter_test();
    logic [31:0] a;
    logic [31:0] b;
    logic [1:0]  r;
    wr_cmp(8'h03, 8'h00, 8'h05);
    for (int s = 0; s < 2; s++)
    begin
      // clear on p (limit 5) then clear on a (limit 3)
      restart(8'hc0 | 8'(s));
      repeat (6)
      begin
        rd(periodic_timer_pkg::OFS_COUNT_LOW, a, r);
        chk("count below limit", 32'h1, {31'h0, a < (s ? 32'h3 : 32'h5)});
      end
    end
    // compare mode, p zero: only overflow clears, so the count passes 512 and wraps
    wr(periodic_timer_pkg::OFS_COMPARE_P_LOW, 8'h00, periodic_timer_pkg::RESP_OKAY);
    restart(8'h00);
    repeat (600) @(posedge clk);
    rd_chk("count high", periodic_timer_pkg::OFS_COUNT_HIGH, 32'h2);
    repeat (500) @(posedge clk);
    rd_chk("count wrapped", periodic_timer_pkg::OFS_COUNT_HIGH, 32'h0);
    wr(periodic_timer_pkg::OFS_RUN_CONTROL, 8'h00, periodic_timer_pkg::RESP_OKAY);
    rd(periodic_timer_pkg::OFS_COUNT_LOW, a, r);
    repeat (5) @(posedge clk);
    rd(periodic_timer_pkg::OFS_COUNT_LOW, b, r);
    chk("frozen count", a, b);
    // external pin as count clock; with ce low the fourth edge is never seen
    wr(periodic_timer_pkg::OFS_RUN_CONTROL, 8'h18, periodic_timer_pkg::RESP_OKAY);
    repeat (3) pulse(1'b1);
    ce <= 1'b0;
    pulse(1'b1);
    ce <= 1'b1;
    rd_chk("external count", periodic_timer_pkg::OFS_COUNT_LOW, 32'h3);
  endtask : counter_test

  task automatic compare_test();
    logic oc;
    logic e;
    wr_cmp(8'h08, 8'h00, 8'h00);
    for (int i = 0; i < 4; i++)
    begin
      // action 00 and 10 with initial high must leave the pin high
      oc = (i != 3);
      e  = (i == 0) ? oc : (i == 1) ? 1'b0 : (i == 2) ? 1'b1 : ~oc;
      restart({2'b00, 2'(i), oc, 3'b000});
      @(posedge clk);
      chk("initial level", {31'h0, oc}, {31'h0, timer_out_pin});
      repeat (20) @(posedge clk);
      chk("level after match", {31'h0, e}, {31'h0, timer_out_pin});
    end
  endtask : compare_test

  task automatic pwm_test();
    int n;
    for (int i = 0; i < 8; i++)
    begin
      restart({3'b100, i[0], i[1], i[2], 2'b00});
      repeat (4) @(posedge clk);
      chk("forced level", {31'h0, (i[0] ? i[1] : ~i[1]) ^ i[2]}, {31'h0, timer_out_pin});
    end
    // period 16, duty 8: exactly half of any 16 consecutive samples are high
    wr_cmp(8'h08, 8'h00, 8'h10);
    restart(8'ha8);
    repeat (8) @(posedge clk);
    n = 0;
    repeat (16)
    begin
      @(posedge clk);
      n += (timer_out_pin === 1'b1);
    end
    chk("pwm high samples", 32'h8, 32'(n));
    restart(8'hcc);
    repeat (4) @(posedge clk);
    chk("timer mode pin", 32'h0, {31'h0, timer_out_pin});
    restart(8'hb8);
    @(posedge clk);
    chk("pulse start", 32'h1, {31'h0, timer_out_pin});
    repeat (20) @(posedge clk);
    chk("pulse end", 32'h0, {31'h0, timer_out_pin});
    rd_chk("run cleared", periodic_timer_pkg::OFS_RUN_CONTROL, 32'h0);
  endtask : pwm_test

  task automatic pulse(input bit on_ext);
    if (on_ext)
      ext_clock_pin <= 1'b1;
    else
      capture_in_pin <= 1'b1;
    repeat (6) @(posedge clk);
    ext_clock_pin  <= 1'b0;
    capture_in_pin <= 1'b0;
    repeat (6) @(posedge clk);
  endtask : pulse

  // compare a preset to 0x3ff; a capture of a count below 0x100 clears its high byte
  task automatic capture_test();
    wr_cmp(8'hff, 8'h03, 8'hff);
    restart(8'h42);
    pulse(1'b0);
    rd_chk("wrong source ignored", periodic_timer_pkg::OFS_COMPARE_A_HI, 32'h3);
    pulse(1'b1);
    rd_chk("capture taken", periodic_timer_pkg::OFS_COMPARE_A_HI, 32'h0);
    // falling only: the rise must leave compare a alone
    wr(periodic_timer_pkg::OFS_COMPARE_A_HI, 8'h03, periodic_timer_pkg::RESP_OKAY);
    restart(8'h50);
    capture_in_pin <= 1'b1;
    repeat (6) @(posedge clk);
    rd_chk("rise ignored", periodic_timer_pkg::OFS_COMPARE_A_HI, 32'h3);
    capture_in_pin <= 1'b0;
    repeat (6) @(posedge clk);
    rd_chk("fall captured", periodic_timer_pkg::OFS_COMPARE_A_HI, 32'h0);
    // both edges capture
    wr(periodic_timer_pkg::OFS_COMPARE_A_HI, 8'h03, periodic_timer_pkg::RESP_OKAY);
    restart(8'h60);
    capture_in_pin <= 1'b1;
    repeat (6) @(posedge clk);
    rd_chk("both edges rise", periodic_timer_pkg::OFS_COMPARE_A_HI, 32'h0);
    wr(periodic_timer_pkg::OFS_COMPARE_A_HI, 8'h03, periodic_timer_pkg::RESP_OKAY);
    capture_in_pin <= 1'b0;
    repeat (6) @(posedge clk);
    rd_chk("both edges fall", periodic_timer_pkg::OFS_COMPARE_A_HI, 32'h0);
    wr(periodic_timer_pkg::OFS_COMPARE_A_HI, 8'h03, periodic_timer_pkg::RESP_OKAY);
    restart(8'h70);
    pulse(1'b0);
    rd_chk("capture disabled", periodic_timer_pkg::OFS_COMPARE_A_HI, 32'h3);
  endtask : capture_test

  // main sequence
  initial
  begin
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    regs_test();
    counter_test();
    compare_test();
    pwm_test();
    capture_test();
    report_and_stop();
  end
endmodule : periodic_timer_test
